// ===== verilog/cfl_pkg.sv
// Purpose: Shared constants and types for the courtesy foot lamp controller
// Assumes: 25 MHz ref_clk; AXI4-Lite register access
// Notes:   Long counts are derived from times in their own units
package cfl_pkg;

    // Clock rate
    localparam longint CLK_HZ = 25_000_000;

    // Documented times
    localparam longint SETTLE_MS  = 1000;  // park settle, 1 s
    localparam longint DEBNC_MS   = 100;   // door open filter, 0.1 s
    localparam longint T30_S      = 30;
    localparam longint T20_MIN    = 20;
    localparam longint FADE_MS    = 2000;  // fade, 2 +/- 0.2 s

    // Derived cycle counts
    localparam longint SETTLE_CYC = CLK_HZ * SETTLE_MS / 1000;
    localparam longint DEBNC_CYC  = CLK_HZ * DEBNC_MS / 1000 + 1;
    localparam longint T30_CYC    = CLK_HZ * T30_S;
    localparam longint T20_CYC    = CLK_HZ * T20_MIN * 60;
    localparam longint FADE_CYC   = CLK_HZ * FADE_MS / 1000;

    // Widths
    localparam int CNT_W  = 36;
    localparam int LVL_W  = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LEVEL  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Control field positions
    localparam int CTRL_SMK_VARIANT = 0;
    localparam int CTRL_ENABLE      = 1;

    // Reset values
    localparam logic [LVL_W-1:0] LEVEL_RST = 8'hff;
    localparam logic [1:0]       CTRL_RST  = 2'h2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Lamp states
    typedef enum logic [2:0] {
        ST_OFF, ST_ON30, ST_ON20M, ST_DECAY, ST_ON
    } cfl_state_e;

    // Body inputs as received over CAN
    typedef struct packed {
        logic ignition_run_input;
        logic all_doors_closed;
        logic all_doors_locked;
        logic all_doors_unlocked;
        logic park_inhibit_state;
        logic remote_key_unlock;
        logic alternate_unlock_source;
        logic smart_key_unlock;
        logic anti_theft_armed;
    } cfl_body_s;

    // AXI4-Lite request side
    typedef struct packed {
        logic       awvalid;
        logic [7:0] awaddr;
        logic       wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       bready;
        logic       arvalid;
        logic [7:0] araddr;
        logic       rready;
    } cfl_axi_req_s;

    // AXI4-Lite answer side
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cfl_axi_rsp_s;

endpackage

// ===== verilog/cfl_axil_regs.sv
// Purpose: AXI4-Lite slave holding the lamp controller's registers
// Assumes: One write and one read outstanding at most
// Notes:   Address and data may arrive in either order
`timescale 1ns/10ps
module cfl_axil_regs (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    // Bus
    input  wire cfl_pkg::cfl_axi_req_s     req,
    output cfl_pkg::cfl_axi_rsp_s          rsp,
    // Block side
    input  wire logic [31:0]               status_word,
    output logic [1:0]                     ctrl,
    output logic [cfl_pkg::LVL_W-1:0]      full_level
);

    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       do_write;

    assign do_write = aw_held && w_held && !rsp.bvalid;

    // Capture address and data independently
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held     <= 1'b0;
            w_held      <= 1'b0;
            aw_addr     <= 8'h00;
            w_data      <= 32'h0000_0000;
            w_strb      <= 4'h0;
            rsp.awready <= 1'b0;
            rsp.wready  <= 1'b0;
        end else begin
            rsp.awready <= 1'b0;
            rsp.wready  <= 1'b0;
            if (req.awvalid && !aw_held && !rsp.awready) begin
                aw_held     <= 1'b1;
                aw_addr     <= req.awaddr;
                rsp.awready <= 1'b1;
            end
            if (req.wvalid && !w_held && !rsp.wready) begin
                w_held     <= 1'b1;
                w_data     <= req.wdata;
                w_strb     <= req.wstrb;
                rsp.wready <= 1'b1;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
        end
    end

    // Register update and write response
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl       <= cfl_pkg::CTRL_RST;
            full_level <= cfl_pkg::LEVEL_RST;
            rsp.bvalid <= 1'b0;
            rsp.bresp  <= cfl_pkg::RESP_OKAY;
        end else begin
            if (rsp.bvalid && req.bready) begin
                rsp.bvalid <= 1'b0;
            end
            if (do_write) begin
                rsp.bvalid <= 1'b1;
                rsp.bresp  <= cfl_pkg::RESP_OKAY;
                unique case (aw_addr)
                    cfl_pkg::ADDR_CTRL: begin
                        if (w_strb[0]) begin
                            ctrl <= w_data[1:0];
                        end
                    end
                    cfl_pkg::ADDR_LEVEL: begin
                        if (w_strb[0]) begin
                            full_level <= w_data[cfl_pkg::LVL_W-1:0];
                        end
                    end
                    // Status is read only; writes are dropped
                    cfl_pkg::ADDR_STATUS: ;
                    default: rsp.bresp <= cfl_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    // Read channel, data valid in the same cycle the address is taken
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rsp.arready <= 1'b0;
            rsp.rvalid  <= 1'b0;
            rsp.rdata   <= 32'h0000_0000;
            rsp.rresp   <= cfl_pkg::RESP_OKAY;
        end else begin
            rsp.arready <= 1'b0;
            if (rsp.rvalid && req.rready) begin
                rsp.rvalid <= 1'b0;
            end
            if (req.arvalid && !rsp.rvalid && !rsp.arready) begin
                rsp.arready <= 1'b1;
                rsp.rvalid  <= 1'b1;
                rsp.rresp   <= cfl_pkg::RESP_OKAY;
                unique case (req.araddr)
                    cfl_pkg::ADDR_CTRL:
                        rsp.rdata <= {30'h0000_0000, ctrl};
                    cfl_pkg::ADDR_LEVEL:
                        rsp.rdata <= {24'h00_0000, full_level};
                    cfl_pkg::ADDR_STATUS:
                        rsp.rdata <= status_word;
                    default: begin
                        rsp.rdata <= 32'h0000_0000;
                        rsp.rresp <= cfl_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule // cfl_axil_regs

// ===== verilog/cfl_foot_lamp.sv
// Purpose: Timed foot courtesy lamp state machine with fade-off
// Assumes: 25 MHz ref_clk; body inputs arrive asynchronously from CAN logic
// Notes:   Lamp level is a brightness code for a PWM stage downstream
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module cfl_foot_lamp (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    // Body inputs from CAN receive logic
    input  wire cfl_pkg::cfl_body_s        body_in,
    // Register bus
    input  wire cfl_pkg::cfl_axi_req_s     axi_req,
    output cfl_pkg::cfl_axi_rsp_s          axi_rsp,
    // Lamp and CAN outputs
    output logic [cfl_pkg::LVL_W-1:0]      lamp_level,
    output logic                           park_inhibit_tx
);

    localparam int NB = $bits(cfl_pkg::cfl_body_s);

    // Truncating load of a timer from a cycle count
    function automatic logic [cfl_pkg::CNT_W-1:0] cyc(input longint n);
        return n[cfl_pkg::CNT_W-1:0];
    endfunction

    logic [NB-1:0]              sync1;
    logic [NB-1:0]              sync2;
    logic [NB-1:0]              sync3;
    cfl_pkg::cfl_body_s         body;
    cfl_pkg::cfl_body_s         body_d;
    cfl_pkg::cfl_state_e        state;
    cfl_pkg::cfl_state_e        next_state;
    logic [cfl_pkg::CNT_W-1:0]  timer;
    logic [cfl_pkg::CNT_W-1:0]  settle_cnt;
    logic [cfl_pkg::CNT_W-1:0]  door_cnt;
    logic                       door_open_ok;
    logic                       door_open_q;
    logic                       settled;
    logic                       unlock_ev;
    logic                       reload;
    logic [1:0]                 ctrl;
    logic [cfl_pkg::LVL_W-1:0]  full_level;
    logic [31:0]                status_word;
    logic                       ign_trig;

    // Three-stage synchroniser; a change counts when stages two and three agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            body  <= '0;
        end else begin
            sync1 <= body_in;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < NB; i++) begin
                if (sync2[i] == sync3[i]) begin
                    body[i] <= sync3[i];
                end
            end
        end
    end

    // Previous inputs, for unlock edge detection
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            body_d <= '0;
        end else begin
            body_d <= body;
        end
    end

    // Unlock is an event: rising edge of remote key unlock, or of smart key unlock when enabled
    always_comb begin
        unlock_ev = body.remote_key_unlock && !body_d.remote_key_unlock;
        if (ctrl[cfl_pkg::CTRL_SMK_VARIANT]) begin
            unlock_ev = unlock_ev
                || (body.smart_key_unlock && !body_d.smart_key_unlock);
        end
    end

    // Door-open filter: open must persist beyond 0.1 s
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            door_cnt     <= '0;
            door_open_ok <= 1'b0;
            door_open_q  <= 1'b0;
        end else begin
            door_open_q <= door_open_ok;
            if (body.all_doors_closed) begin
                door_cnt     <= '0;
                door_open_ok <= 1'b0;
            end else if (door_cnt < cyc(cfl_pkg::DEBNC_CYC)) begin
                door_cnt <= door_cnt + 1'b1;
            end else begin
                door_open_ok <= 1'b1;
            end
        end
    end

    // Park settle timer: ignition must stay on for 1 s
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            settle_cnt <= '0;
        end else if (!body.ignition_run_input) begin
            settle_cnt <= '0;
        end else if (settle_cnt < cyc(cfl_pkg::SETTLE_CYC)) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end
    assign settled = (settle_cnt == cyc(cfl_pkg::SETTLE_CYC));

    // Shared ignition trigger for off and decaying states
    assign ign_trig = body.ignition_run_input
        && (!body.all_doors_closed || body.park_inhibit_state);

    // Next-state logic
    always_comb begin
        next_state = state;
        reload     = 1'b0;
        unique case (state)
            cfl_pkg::ST_OFF: begin
                if (ign_trig) begin
                    next_state = cfl_pkg::ST_ON;
                end else if (!body.ignition_run_input
                             && door_open_ok && !door_open_q) begin
                    next_state = cfl_pkg::ST_ON20M;
                end else if (!body.ignition_run_input
                             && body.all_doors_closed && unlock_ev) begin
                    next_state = cfl_pkg::ST_ON30;
                end
            end
            cfl_pkg::ST_ON30: begin
                if (body.ignition_run_input && settled) begin
                    if (body.park_inhibit_state) begin
                        next_state = cfl_pkg::ST_ON;
                    end else begin
                        next_state = cfl_pkg::ST_DECAY;
                    end
                end else if (!body.ignition_run_input) begin
                    if (timer == '0 || body.anti_theft_armed
                        || body.all_doors_locked) begin
                        next_state = cfl_pkg::ST_DECAY;
                    end else if (door_open_ok && !door_open_q) begin
                        next_state = cfl_pkg::ST_ON20M;
                    end else if (unlock_ev) begin
                        reload = 1'b1;
                    end
                end
            end
            cfl_pkg::ST_ON20M: begin
                if (body.ignition_run_input) begin
                    next_state = cfl_pkg::ST_ON;
                end else if ((body.all_doors_closed
                              && body.all_doors_locked) || timer == '0) begin
                    next_state = cfl_pkg::ST_DECAY;
                end else if (body.all_doors_closed
                             && body.all_doors_unlocked) begin
                    next_state = cfl_pkg::ST_ON30;
                end
            end
            cfl_pkg::ST_DECAY: begin
                if (ign_trig) begin
                    next_state = cfl_pkg::ST_ON;
                end else if (!body.ignition_run_input
                             && door_open_ok && !door_open_q) begin
                    next_state = cfl_pkg::ST_ON20M;
                end else if (!body.ignition_run_input
                             && body.all_doors_closed
                             && (unlock_ev
                                 || (body.alternate_unlock_source
                                     && !body_d.alternate_unlock_source)))
                begin
                    next_state = cfl_pkg::ST_ON30;
                end else if (timer == '0) begin
                    next_state = cfl_pkg::ST_OFF;
                end
            end
            cfl_pkg::ST_ON: begin
                if (!body.ignition_run_input && body.all_doors_closed) begin
                    next_state = cfl_pkg::ST_ON30;
                    reload     = 1'b1;
                end else if (!body.ignition_run_input) begin
                    next_state = cfl_pkg::ST_ON20M;
                end else if (body.all_doors_closed
                             && !body.park_inhibit_state) begin
                    next_state = cfl_pkg::ST_DECAY;
                end
            end
        endcase
    end

    // State register
    // reset to off
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= cfl_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // State timer, loaded on each entry or on a restart
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timer <= '0;
        end else if (next_state != state || reload) begin
            unique case (next_state)
                cfl_pkg::ST_ON30:  timer <= cyc(cfl_pkg::T30_CYC);
                cfl_pkg::ST_ON20M: timer <= cyc(cfl_pkg::T20_CYC);
                cfl_pkg::ST_DECAY: timer <= cyc(cfl_pkg::FADE_CYC);
                default:           timer <= '0;
            endcase
        end else if (timer != '0) begin
            timer <= timer - 1'b1;
        end
    end

    // Lamp drive: linear fade scaled from the configured full level
    // configurable full level
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lamp_level <= '0;
        end else if (!ctrl[cfl_pkg::CTRL_ENABLE]) begin
            lamp_level <= '0;
        end else begin
            unique case (next_state)
                cfl_pkg::ST_OFF:   lamp_level <= '0;
                // Entry edge still holds the old state's timer
                cfl_pkg::ST_DECAY: lamp_level <= (state != cfl_pkg::ST_DECAY)
                    ? full_level : cfl_pkg::LVL_W'(
                    (64'(timer) * full_level) / cfl_pkg::FADE_CYC);
                default:           lamp_level <= full_level;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            park_inhibit_tx <= 1'b0;
        end else begin
            park_inhibit_tx <= body.park_inhibit_state;
        end
    end

    // Status readback
    assign status_word = {16'h0000, lamp_level, 3'h0,
                          body.park_inhibit_state, 1'b0, state};

    // Register slave
    cfl_axil_regs u_regs (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .req         (axi_req),
        .rsp         (axi_rsp),
        .status_word (status_word),
        .ctrl        (ctrl),
        .full_level  (full_level)
    );

endmodule // cfl_foot_lamp

// ===== tb/cfl_foot_lamp_asserts.sv
// Purpose: Port-level checks for the foot lamp controller
// Assumes: One ref_clk domain, resetn async active low
// Notes:   Bound to every cfl_foot_lamp instance
`timescale 1ns/10ps
module cfl_foot_lamp_asserts (
    // Clock and reset
    input wire logic                        ref_clk,
    input wire logic                        resetn,
    // Watched ports
    input wire cfl_pkg::cfl_body_s          body_in,
    input wire cfl_pkg::cfl_axi_req_s       axi_req,
    input wire cfl_pkg::cfl_axi_rsp_s       axi_rsp,
    input wire logic [cfl_pkg::LVL_W-1:0]   lamp_level,
    input wire logic                        park_inhibit_tx
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_reset_dark;
        $rose(resetn) |-> lamp_level == '0;
    endproperty
    a_reset_dark: assert property (p_reset_dark)
        else $error("lamp lit at reset release");
    property p_park_rise;
        $rose(body_in.park_inhibit_state) |-> ##[1:8] park_inhibit_tx;
    endproperty
    a_park_rise: assert property (p_park_rise)
        else $error("park state not reported");
    property p_park_fall;
        $fell(body_in.park_inhibit_state) |-> ##[1:8] !park_inhibit_tx;
    endproperty
    a_park_fall: assert property (p_park_fall)
        else $error("park release not reported");
    property p_door_lit;
        (body_in.ignition_run_input && !body_in.all_doors_closed) [*8]
            |-> lamp_level != '0;
    endproperty
    a_door_lit: assert property (p_door_lit)
        else $error("lamp dark with ignition and open door");
    property p_park_lit;
        (body_in.ignition_run_input && body_in.park_inhibit_state) [*8]
            |-> lamp_level != '0;
    endproperty
    a_park_lit: assert property (p_park_lit)
        else $error("lamp dark with ignition and park");
    property p_wr_take;
        axi_req.awvalid && axi_req.wvalid && !axi_rsp.awready
            && !axi_rsp.wready && !axi_rsp.bvalid
            |=> axi_rsp.awready && axi_rsp.wready;
    endproperty
    a_wr_take: assert property (p_wr_take)
        else $error("write not taken in one cycle");
    property p_wr_resp;
        axi_rsp.awready && axi_rsp.wready |=> axi_rsp.bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    property p_rd_answer;
        axi_req.arvalid && !axi_rsp.arready && !axi_rsp.rvalid
            |=> axi_rsp.arready && axi_rsp.rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered in one cycle");
endmodule // cfl_foot_lamp_asserts

bind cfl_foot_lamp cfl_foot_lamp_asserts cfl_foot_lamp_asserts_i (
    .ref_clk(ref_clk), .resetn(resetn), .body_in(body_in),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .lamp_level(lamp_level),
    .park_inhibit_tx(park_inhibit_tx));

// ===== tb/cfl_body_model.sv
// Purpose: Body-side CAN inputs as seen by the lamp controller
// Assumes: Levels from the bench, unlocks as short pulses
// Notes:   Pulses outlast the controller's input synchroniser
`timescale 1ns/10ps
module cfl_body_model (
    // Clock and reset
    input wire logic          ref_clk,
    input wire logic          resetn,
    // Bench commands
    input wire logic          ign,
    input wire logic          door_open,
    input wire logic          locked,
    input wire logic          park,
    input wire logic          armed,
    input wire logic          unlock_go,
    input wire logic [1:0]    unlock_kind,
    // Frame contents
    output cfl_pkg::cfl_body_s body
);
    logic [3:0] hold;
    logic [1:0] kind;

    // Unlock pulse stretcher; a one-cycle pulse could be lost in sync
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold <= 4'h0;
            kind <= 2'h0;
        end else if (unlock_go) begin
            hold <= 4'h8;
            kind <= unlock_kind;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end

    // Frame fields; unlocked is simply the inverse of locked
    always_comb begin
        body.ignition_run_input      = ign;
        body.all_doors_closed        = !door_open;
        body.all_doors_locked        = locked;
        body.all_doors_unlocked      = !locked;
        body.park_inhibit_state      = park;
        body.remote_key_unlock       = hold != 4'h0 && kind == 2'h0;
        body.alternate_unlock_source = hold != 4'h0 && kind == 2'h1;
        body.smart_key_unlock        = hold != 4'h0 && kind == 2'h2;
        body.anti_theft_armed        = armed;
    end
endmodule // cfl_body_model

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the foot lamp controller
// Assumes: Long timers never expire within the run
// Notes:   State is read back through the status register
`timescale 1ns/10ps
module tb_top;
    logic                  ref_clk = 1'b0;
    logic                  resetn = 1'b0;
    logic                  ign = 1'b0, door = 1'b0, lock = 1'b0;
    logic                  park = 1'b0, armed = 1'b0, go = 1'b0;
    logic [1:0]            kind = 2'h0;
    logic [7:0]            lvl, lamp;
    logic [31:0]           rd;
    logic [1:0]            resp;
    logic                  park_tx;
    int                    n_errors = 0, check_count = 0, cycles = 0;
    cfl_pkg::cfl_body_s    body;
    cfl_pkg::cfl_axi_req_s req = '0;
    cfl_pkg::cfl_axi_rsp_s rsp;

    // Clock, 40 ns period
    always #20 ref_clk = ~ref_clk;

    cfl_body_model cfl_body_model_i (
        .ref_clk(ref_clk), .resetn(resetn), .ign(ign), .door_open(door),
        .locked(lock), .park(park), .armed(armed), .unlock_go(go),
        .unlock_kind(kind), .body(body));
    cfl_foot_lamp cfl_foot_lamp_i (
        .ref_clk(ref_clk), .resetn(resetn), .body_in(body),
        .axi_req(req), .axi_rsp(rsp), .lamp_level(lamp),
        .park_inhibit_tx(park_tx));

    // Hang guard; the run needs only a few hundred cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            results();
        end
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Write: both channels offered together, each dropped once taken
    // No cycle limit here; a lost answer is caught by the hang guard
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d,
                 wstrb: 4'hf, bready: 1'b1, default: '0};
        do begin
            @(posedge ref_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        resp = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Read: rready held until the data is seen
    task automatic axi_rd(input logic [7:0] a);
        req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        do begin
            @(posedge ref_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Expected brightness; fading values are not predicted
    function automatic logic [31:0] lit(input cfl_pkg::cfl_state_e st);
        return (st == cfl_pkg::ST_OFF) ? 32'h0 : {24'h0, lvl};
    endfunction

    // Body bits are ign, door open, locked, park, armed
    task automatic step(input logic [4:0] b, input cfl_pkg::cfl_state_e st);
        {ign, door, lock, park, armed} <= b;
        repeat (12) @(posedge ref_clk);
        axi_rd(cfl_pkg::ADDR_STATUS);
        chk("state", {29'h0, rd[2:0]}, {29'h0, st});
        chk("park_tx", {31'h0, park_tx}, {31'h0, park});
        if (st != cfl_pkg::ST_DECAY)
            chk("lamp", {24'h0, lamp}, lit(st));
        else
            chk("fade", {31'h0, lamp <= lvl && lamp >= lvl - 1}, 1);
        $display("step %h done, state %0d", b, st);
    endtask

    task automatic unlock(input logic [1:0] k);
        kind <= k;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask

    initial begin
        void'($urandom(32'h6379dab6));
        lvl = 8'h01 + 8'($urandom % 255);
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        chk("lamp_rst", {24'h0, lamp}, 32'h0);
        axi_rd(cfl_pkg::ADDR_LEVEL);
        chk("level_rst", rd, 32'h0000_00ff);
        axi_rd(cfl_pkg::ADDR_CTRL);
        chk("ctrl_rst", rd, 32'h0000_0002);
        axi_rd(8'h0c);
        chk("rd_unmapped", rd, 32'h0);
        chk("rresp", {30'h0, resp}, {30'h0, cfl_pkg::RESP_SLVERR});
        axi_wr(8'h0c, 32'h0000_0001);
        chk("bresp", {30'h0, resp}, {30'h0, cfl_pkg::RESP_SLVERR});
        axi_wr(cfl_pkg::ADDR_STATUS, 32'h0000_0004);
        chk("wr_status", {30'h0, resp}, 32'h0);
        axi_wr(cfl_pkg::ADDR_CTRL, 32'h0000_0003);
        axi_wr(cfl_pkg::ADDR_LEVEL, {24'h0, lvl});
        axi_rd(cfl_pkg::ADDR_LEVEL);
        chk("level", rd, {24'h0, lvl});
        $display("test registers done");
        step(5'h00, cfl_pkg::ST_OFF);
        step(5'h18, cfl_pkg::ST_ON);
        step(5'h08, cfl_pkg::ST_ON20M);
        step(5'h18, cfl_pkg::ST_ON);
        step(5'h08, cfl_pkg::ST_ON20M);
        step(5'h00, cfl_pkg::ST_ON30);
        step(5'h01, cfl_pkg::ST_DECAY);
        // Every unlock source, fresh random brightness each time
        for (int k = 0; k < 3; k++) begin
            step(5'h00, cfl_pkg::ST_DECAY);
            lvl = 8'h01 + 8'($urandom % 255);
            axi_wr(cfl_pkg::ADDR_LEVEL, {24'h0, lvl});
            unlock(k[1:0]);
            step(5'h00, cfl_pkg::ST_ON30);
            step(5'h04, cfl_pkg::ST_DECAY);
        end
        step(5'h12, cfl_pkg::ST_ON);
        step(5'h18, cfl_pkg::ST_ON);
        step(5'h10, cfl_pkg::ST_DECAY);
        step(5'h18, cfl_pkg::ST_ON);
        step(5'h00, cfl_pkg::ST_ON30);
        step(5'h04, cfl_pkg::ST_DECAY);
        step(5'h18, cfl_pkg::ST_ON);
        step(5'h0c, cfl_pkg::ST_ON20M);
        step(5'h04, cfl_pkg::ST_DECAY);
        $display("test transitions done");
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("lamp_in_reset", {24'h0, lamp}, 32'h0);
        resetn <= 1'b1;
        @(posedge ref_clk);
        step(5'h04, cfl_pkg::ST_OFF);
        // Level is back at its reset value; smart key not enabled
        lvl = cfl_pkg::LEVEL_RST;
        unlock(2'h2);
        step(5'h00, cfl_pkg::ST_OFF);
        unlock(2'h0);
        step(5'h00, cfl_pkg::ST_ON30);
        // Disabled lamp stays dark whatever the state
        axi_wr(cfl_pkg::ADDR_CTRL, 32'h0);
        lvl = 8'h00;
        step(5'h00, cfl_pkg::ST_ON30);
        $display("test second reset done");
        results();
    end
endmodule // tb_top
